/* File: iafl_alu.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module iafl_alu (
    input  wire logic                 aclk,          // core clock
    input  wire logic                 aresetn,       // sync reset, low
    input  wire logic                 req_valid,     // operation strobe
    input  wire iafl_pkg::iafl_op_t   req_op,        // operation select
    input  wire logic [31:0]          req_src_a,     // first_src_reg value
    input  wire logic [31:0]          req_src_b,     // flex_second_operand
    input  wire logic                 req_imm_sel,   // use short_immediate
    input  wire logic [11:0]          req_short_imm, // short_immediate
    input  wire logic [31:0]          req_amt_reg,   // shift_amount_reg
    input  wire logic                 req_sh_imm_sel,// immediate count
    input  wire logic [5:0]           req_sh_imm,    // immediate count
    input  wire logic                 req_set_flags, // flag update wanted
    input  wire logic                 req_sh_c_vld,  // shifter gave carry
    input  wire logic                 req_sh_c,      // shifter carry out
    input  wire logic                 req_base_pc,   // first source is pc
    input  wire logic                 req_dst_pc,    // destination is pc
    input  wire logic                 req_dst_vld,   // destination present
    input  wire logic [3:0]           req_dst_idx,   // destination index
    input  wire logic [3:0]           req_src_idx,   // first source index
    output logic                      res_valid,     // result strobe
    output logic [31:0]               res_data,      // result value
    output logic                      res_wr_en,     // write register file
    output logic [3:0]                res_wr_idx,    // register to write
    output logic                      br_valid,      // branch strobe
    output logic [31:0]               br_target,     // branch address
    output logic [3:0]                flags_out,     // n z c v
    input  wire logic [7:0]           s_axi_awaddr,  // write address
    input  wire logic                 s_axi_awvalid, // write addr valid
    output logic                      s_axi_awready, // write addr ready
    input  wire logic [31:0]          s_axi_wdata,   // write data
    input  wire logic [3:0]           s_axi_wstrb,   // byte enables
    input  wire logic                 s_axi_wvalid,  // write data valid
    output logic                      s_axi_wready,  // write data ready
    output logic [1:0]                s_axi_bresp,   // write response
    output logic                      s_axi_bvalid,  // response valid
    input  wire logic                 s_axi_bready,  // response ready
    input  wire logic [7:0]           s_axi_araddr,  // read address
    input  wire logic                 s_axi_arvalid, // read addr valid
    output logic                      s_axi_arready, // read addr ready
    output logic [31:0]               s_axi_rdata,   // read data
    output logic [1:0]                s_axi_rresp,   // read response
    output logic                      s_axi_rvalid,  // read data valid
    input  wire logic                 s_axi_rready   // read data ready
);
    // ========================================================
    // functions
    // ========================================================
    // returns {overflow, carry, sum}
    function automatic logic [33:0] add_vc(input logic [31:0] x,
                                           input logic [31:0] y,
                                           input logic        ci);
        logic [32:0] s;
        s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
        add_vc = {(x[31] == y[31]) && (s[31] != x[31]), s};
    endfunction

    // returns {carry out, shifted value}
    function automatic logic [32:0] shift_c(input iafl_pkg::iafl_op_t op,
                                            input logic [31:0] a,
                                            input logic [7:0]  n,
                                            input logic        ci);
        logic [63:0] t;
        t = '0;
        shift_c = {ci, a};
        case (op)
            iafl_pkg::OP_SHL: begin
                if (n > iafl_pkg::WORD_BITS) begin
                    shift_c = '0;
                end else if (n != 8'h00) begin
                    t = {32'h0, a} << n;
                    shift_c = t[32:0];
                end
            end
            iafl_pkg::OP_SHR: begin
                if (n > iafl_pkg::WORD_BITS) begin
                    shift_c = '0;
                end else if (n != 8'h00) begin
                    t = {a, 32'h0} >> n;
                    shift_c = {t[31], t[63:32]};
                end
            end
            iafl_pkg::OP_SAR: begin
                if (n >= iafl_pkg::WORD_BITS) begin
                    shift_c = {33{a[31]}};
                end else if (n != 8'h00) begin
                    t = $signed({a, 32'h0}) >>> n;
                    shift_c = {t[31], t[63:32]};
                end
            end
            iafl_pkg::OP_ROTR: begin
                if (n != 8'h00) begin
                    t = {a, a} >> n[4:0];
                    shift_c = {t[31], t[31:0]};
                end
            end
            iafl_pkg::OP_ROTX: shift_c = {a[0], ci, a[31:1]};
            default: shift_c = {ci, a};
        endcase
    endfunction

    // count of zero bits above the highest set bit
    function automatic logic [5:0] lzc(input logic [31:0] a);
        logic found;
        found = 1'b0;
        lzc = iafl_pkg::LZC_EMPTY;
        for (int i = 31; i >= 0; i--) begin
            if (!found && a[i]) begin
                lzc = 6'(31 - i);
                found = 1'b1;
            end
        end
    endfunction

    // ========================================================
    // datapath
    // ========================================================
    logic [3:0]  flags_q;
    logic [31:0] last_q;
    logic [31:0] count_q;
    logic [31:0] a_eff;
    logic [31:0] b_eff;
    logic [7:0]  sh_n;
    logic [33:0] ar;
    logic [32:0] sr;
    logic [31:0] res_d;
    logic [3:0]  flags_d;
    logic        upd_d;
    logic        wr_d;
    logic        br_d;
    logic        is_arith;
    logic        is_logic;
    logic        is_shift;
    logic        cin;

    assign cin = flags_q[iafl_pkg::FLAG_C];

    // operand conditioning; immediate is zero-extended
    always_comb begin
        a_eff = req_base_pc ? (req_src_a & iafl_pkg::PC_ALIGN)
                            : req_src_a;
        b_eff = req_imm_sel ? {20'h0, req_short_imm} : req_src_b;
        // register counts keep only the low byte
        sh_n  = req_sh_imm_sel ? {2'h0, req_sh_imm}
                               : req_amt_reg[7:0];
    end

    // one adder serves every add and subtract form
    always_comb begin
        case (req_op)
            iafl_pkg::OP_ADC: ar = add_vc(a_eff, b_eff, cin);
            iafl_pkg::OP_SUB,
            iafl_pkg::OP_CSUB: ar = add_vc(a_eff, ~b_eff, 1'b1);
            iafl_pkg::OP_SBB: ar = add_vc(a_eff, ~b_eff, cin);
            iafl_pkg::OP_RSUB: ar = add_vc(b_eff, ~a_eff, 1'b1);
            default:          ar = add_vc(a_eff, b_eff, 1'b0);
        endcase
    end

    assign sr = shift_c(req_op, req_src_b, sh_n, cin);

    // result, flag and write-back selection
    always_comb begin
        is_arith = (req_op <= iafl_pkg::OP_RSUB);
        is_logic = (req_op >= iafl_pkg::OP_AND) &&
                   (req_op <= iafl_pkg::OP_ORNT);
        is_shift = (req_op >= iafl_pkg::OP_SHL) &&
                   (req_op <= iafl_pkg::OP_ROTX);
        res_d    = ar[31:0];
        flags_d  = flags_q;
        upd_d    = 1'b0;
        wr_d     = 1'b1;
        br_d     = 1'b0;
        case (req_op)
            iafl_pkg::OP_AND:  res_d = req_src_a & req_src_b;
            iafl_pkg::OP_XOR:  res_d = req_src_a ^ req_src_b;
            iafl_pkg::OP_OR:   res_d = req_src_a | req_src_b;
            iafl_pkg::OP_ANDN: res_d = req_src_a & ~req_src_b;
            iafl_pkg::OP_ORNT: res_d = req_src_a | ~req_src_b;
            iafl_pkg::OP_LZC:  res_d = {26'h0, lzc(req_src_b)};
            default:           res_d = is_shift ? sr[31:0] : ar[31:0];
        endcase
        if (is_arith || req_op == iafl_pkg::OP_CSUB ||
            req_op == iafl_pkg::OP_CADD) begin
            flags_d = {res_d[31], res_d == 32'h0, ar[32], ar[33]};
            upd_d   = req_set_flags || !is_arith;
        end else if (is_logic || is_shift) begin
            flags_d[iafl_pkg::FLAG_N] = res_d[31];
            flags_d[iafl_pkg::FLAG_Z] = (res_d == 32'h0);
            if (is_shift) begin
                flags_d[iafl_pkg::FLAG_C] = sr[32];
            end else if (req_sh_c_vld) begin
                flags_d[iafl_pkg::FLAG_C] = req_sh_c;
            end
            upd_d   = req_set_flags;
        end
        // compares discard the result
        if (req_op == iafl_pkg::OP_CSUB || req_op == iafl_pkg::OP_CADD) begin
            wr_d = 1'b0;
        end
        // an add into the pc becomes a branch, not a write
        if (req_op == iafl_pkg::OP_ADD && req_dst_pc) begin
            br_d = 1'b1;
            wr_d = 1'b0;
        end
    end

    // registered result port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_valid  <= 1'b0;
            res_data   <= 32'h0;
            res_wr_en  <= 1'b0;
            res_wr_idx <= 4'h0;
            br_valid   <= 1'b0;
            br_target  <= 32'h0;
        end else begin
            res_valid  <= req_valid;
            res_wr_en  <= req_valid && wr_d;
            br_valid   <= req_valid && br_d;
            if (req_valid) begin
                res_data   <= res_d;
                br_target  <= res_d & iafl_pkg::BR_ALIGN;
                // shifts always name a destination
                res_wr_idx <= (req_dst_vld || is_shift) ? req_dst_idx
                                                        : req_src_idx;
            end
        end
    end

    // ========================================================
    // register bus slave
    // ========================================================
    logic       wr_fire;
    logic       rd_fire;
    logic       sw_flags;

    assign wr_fire  = s_axi_awready && s_axi_awvalid &&
                      s_axi_wready && s_axi_wvalid;
    assign rd_fire  = s_axi_arready && s_axi_arvalid;
    assign sw_flags = wr_fire && s_axi_wstrb[0] &&
                      (s_axi_awaddr == iafl_pkg::REG_FLAGS);

    // write channel: both address and data are taken on one edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= iafl_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !s_axi_awready && !s_axi_bvalid &&
                             s_axi_awvalid && s_axi_wvalid;
            s_axi_wready  <= !s_axi_awready && !s_axi_bvalid &&
                             s_axi_awvalid && s_axi_wvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                if (s_axi_awaddr == iafl_pkg::REG_FLAGS ||
                    s_axi_awaddr == iafl_pkg::REG_RESULT ||
                    s_axi_awaddr == iafl_pkg::REG_COUNT) begin
                    s_axi_bresp <= iafl_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= iafl_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= iafl_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
                             s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= iafl_pkg::RESP_OKAY;
                if (s_axi_araddr == iafl_pkg::REG_FLAGS) begin
                    s_axi_rdata <= {28'h0, flags_q};
                end else if (s_axi_araddr == iafl_pkg::REG_RESULT) begin
                    s_axi_rdata <= last_q;
                end else if (s_axi_araddr == iafl_pkg::REG_COUNT) begin
                    s_axi_rdata <= count_q;
                end else begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= iafl_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // flags: a datapath update wins over a software write on one edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= iafl_pkg::FLAGS_RST;
        end else if (req_valid && upd_d) begin
            flags_q <= flags_d;
        end else if (sw_flags) begin
            flags_q <= s_axi_wdata[3:0];
        end
    end

    assign flags_out = flags_q;

    // last result and operation count seen by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_q  <= 32'h0;
            count_q <= 32'h0;
        end else if (req_valid) begin
            last_q  <= res_d;
            count_q <= count_q + 32'h1;
        end
    end

    // ========================================================
    // checks
    // ========================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_add_req;
        req_valid && req_op == iafl_pkg::OP_ADD && !req_base_pc;
    endsequence

    chk_add_result: assert property (
        s_add_req |=> res_valid && res_data == $past(req_src_a) +
            ($past(req_imm_sel) ? {20'h0, $past(req_short_imm)}
                                : $past(req_src_b)))
        else $error("add result wrong");
    chk_sub_result: assert property (
        req_valid && req_op == iafl_pkg::OP_SUB && !req_imm_sel &&
        !req_base_pc |=> res_data == $past(req_src_a) - $past(req_src_b))
        else $error("subtract result wrong");
    chk_sbb_borrow: assert property (
        req_valid && req_op == iafl_pkg::OP_SBB && !cin && !req_base_pc
        |=> res_data == $past(req_src_a) - $past(req_src_b) - 32'h1)
        else $error("borrow not applied");
    chk_rsub_order: assert property (
        req_valid && req_op == iafl_pkg::OP_RSUB && !req_imm_sel &&
        !req_base_pc |=> res_data == $past(req_src_b) - $past(req_src_a))
        else $error("reverse subtract wrong");
    chk_dst_default: assert property (
        req_valid && req_op == iafl_pkg::OP_AND && !req_dst_vld
        |=> res_wr_en && res_wr_idx == $past(req_src_idx))
        else $error("default destination wrong");
    chk_branch_even: assert property (
        s_add_req ##0 req_dst_pc |=> br_valid && !res_wr_en &&
            !br_target[0] && br_target[31:1] == res_data[31:1])
        else $error("branch target wrong");
    chk_lzc_flags: assert property (
        req_valid && req_op == iafl_pkg::OP_LZC && req_src_b == 32'h0
        ##0 !sw_flags |=> res_data == 32'h20 && $stable(flags_q))
        else $error("leading zero count wrong");
    chk_csub_flags: assert property (
        req_valid && req_op == iafl_pkg::OP_CSUB && !req_set_flags &&
        !req_imm_sel && !req_base_pc |=> !res_wr_en &&
        flags_q[iafl_pkg::FLAG_Z] == ($past(req_src_a) == $past(req_src_b))
        && flags_q[iafl_pkg::FLAG_C] == ($past(req_src_a) >= $past(req_src_b)))
        else $error("compare flags wrong");
    chk_logic_v_hold: assert property (
        req_valid && req_op == iafl_pkg::OP_OR && !sw_flags
        |=> flags_q[iafl_pkg::FLAG_V] == $past(flags_q[iafl_pkg::FLAG_V]))
        else $error("logic op changed overflow");
    chk_flags_hold: assert property (
        req_valid && !req_set_flags && req_op != iafl_pkg::OP_CSUB &&
        req_op != iafl_pkg::OP_CADD && !sw_flags |=> $stable(flags_q))
        else $error("flags changed without request");
endmodule

/* File: iafl_pkg.sv */
package iafl_pkg;
    localparam int          DATA_W      = 32;
    localparam int          IDX_W       = 4;
    localparam int          IMM_W       = 12;
    localparam int          SH_IMM_W    = 6;
    localparam int          AMT_W       = 8;
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  WORD_BITS   = 8'h20;
    localparam logic [5:0]  LZC_EMPTY   = 6'h20;
    // condition flag bit positions
    localparam int          FLAG_N      = 3;
    localparam int          FLAG_Z      = 2;
    localparam int          FLAG_C      = 1;
    localparam int          FLAG_V      = 0;
    localparam logic [3:0]  FLAGS_RST   = 4'h0;
    localparam logic [31:0] PC_ALIGN    = 32'hFFFFFFFC;
    localparam logic [31:0] BR_ALIGN    = 32'hFFFFFFFE;
    // register map
    localparam logic [7:0]  REG_FLAGS   = 8'h00;
    localparam logic [7:0]  REG_RESULT  = 8'h04;
    localparam logic [7:0]  REG_COUNT   = 8'h08;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    typedef enum logic [4:0] {
        OP_ADD  = 5'h00, OP_ADC  = 5'h01, OP_SUB  = 5'h02, OP_SBB  = 5'h03,
        OP_RSUB = 5'h04, OP_AND  = 5'h05, OP_XOR  = 5'h06, OP_OR   = 5'h07,
        OP_ANDN = 5'h08, OP_ORNT = 5'h09, OP_SHL  = 5'h0A, OP_SHR  = 5'h0B,
        OP_SAR  = 5'h0C, OP_ROTR = 5'h0D, OP_ROTX = 5'h0E, OP_LZC  = 5'h0F,
        OP_CSUB = 5'h10, OP_CADD = 5'h11
    } iafl_op_t;
endpackage

/* File: iafl_rf.sv */
`timescale 1ns/10ps
// ==============================================================
// register file model on the far side of the result port
module iafl_rf (
    input  wire logic        aclk,    // core clock
    input  wire logic        wr_en,   // write strobe
    input  wire logic [3:0]  wr_idx,  // target register
    input  wire logic [31:0] wr_data, // value written
    input  wire logic [3:0]  rd_idx,  // register looked at
    output logic [31:0]      rd_data  // its value
);
    logic [31:0] mem_q [16];
    // a write lands on the edge that samples the strobe
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end
    assign rd_data = mem_q[rd_idx];
endmodule

/* File: integer_alu_flag_logic_tb.sv */
`timescale 1ns/10ps
// ==============================================================
// bench: random and corner operations, bus access to the flags
module integer_alu_flag_logic_tb;
    logic aclk = 0, aresetn = 0, req_valid, req_imm_sel, req_sh_imm_sel;
    logic req_set_flags, req_sh_c_vld, req_sh_c, req_base_pc, req_dst_pc;
    logic req_dst_vld, res_valid, res_wr_en, br_valid, s_axi_awvalid;
    logic s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready;
    iafl_pkg::iafl_op_t req_op;
    logic [31:0] req_src_a, req_src_b, req_amt_reg, res_data, br_target;
    logic [31:0] s_axi_wdata, s_axi_rdata, rf_q, q, lr;
    logic [11:0] req_short_imm;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [5:0]  req_sh_imm;
    logic [3:0]  req_dst_idx, req_src_idx, res_wr_idx, flags_out, ef, rf_idx;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int errors = 0, check_count = 0, cyc = 0, seed = 61, k;
    iafl_alu u_iafl_alu (.*);
    iafl_rf u_iafl_rf (.aclk(aclk), .wr_en(res_wr_en), .wr_idx(res_wr_idx),
        .wr_data(res_data), .rd_idx(rf_idx), .rd_data(rf_q));
    always #2.5 aclk = ~aclk;
    task chk(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard: a limit well above the expected run counts as a fault
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            finish_test;
        end
    end
    // one bus access; each valid is held until its own ready is seen
    task ax(input bit wr, input logic [7:0] ad, input logic [31:0] d);
        bit a, w;
        a = 0;
        w = !wr;
        @(posedge aclk);
        if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid,
            s_axi_bready} <= {ad, d, 3'h7};
        else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
        do begin
            @(posedge aclk);
            if (wr ? s_axi_awready : s_axi_arready) begin
                a = 1;
                {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            end
            if (wr && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 0;
            end
        end while (!(a && w));
        while (!(wr ? s_axi_bvalid : s_axi_rvalid)) @(posedge aclk);
        rs = wr ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask
    // expected {n,z,c,v,result}; codes 0-4 adder, 5-9 logic, 10-14 shift
    function automatic logic [35:0] ref_f(input logic [4:0] o,
        input logic [31:0] a, b, input logic [7:0] n, input logic [3:0] f,
        input logic s, cv, cs);
        logic [32:0] t;
        logic [31:0] r, x, y;
        logic c, v;
        x = (o == 4) ? b : a;
        y = (o inside {2, 3, 16}) ? ~b : (o == 4) ? ~a : b;
        t = x + y + ((o inside {2, 4, 16}) ? 1'b1 : (o inside {1, 3}) & f[1]);
        {c, r} = {f[1], t[31:0]};
        v = (x[31] == y[31]) && (r[31] != x[31]);
        case (o)
            5: r = a & b;
            6: r = a ^ b;
            7: r = a | b;
            8: r = a & ~b;
            9: r = a | ~b;
            10: {r, c} = {(n > 31) ? 32'h0 : b << n,
                (n == 0) ? c : (n > 32) ? 1'b0 : b[32 - n]};
            11: {r, c} = {(n > 31) ? 32'h0 : b >> n,
                (n == 0) ? c : (n > 32) ? 1'b0 : b[n - 1]};
            12: {r, c} = {(n > 31) ? {32{b[31]}} : 32'($signed(b) >>> n),
                (n == 0) ? c : (n > 31) ? b[31] : b[n - 1]};
            13: {r, c} = {(b >> n % 32) | (b << (32 - n % 32)),
                (n == 0) ? c : b[(n + 31) % 32]};
            14: {r, c} = {f[1], b};
            15: for (int i = 0; i <= 32; i++) if (i == 32 || b[31 - i]) begin
                r = i;
                break;
            end
            default: c = t[32];
        endcase
        if (o >= 16 || s && o <= 4) f = {r[31], r == 0, c, v};
        else if (s && o <= 9) f = {r[31], r == 0, cv ? cs : f[1], f[0]};
        else if (s && o <= 14) f = {r[31], r == 0, c, f[0]};
        return {f, r};
    endfunction
    // one operation; z gives all-ones first source, zero operand, count 0
    task op(input logic [4:0] o, input bit z);
        logic [31:0] a, b, m;
        logic [35:0] e;
        logic [11:0] i;
        logic [5:0] h;
        logic [3:0] di, si;
        logic is, hs, s, cv, cs, pc, dp, dv, we;
        @(posedge aclk);
        {a, b, m} = {$random(seed), $random(seed), $random(seed)};
        {i, h, is, hs, s, cv, cs, pc, dp, dv, di, si} =
            34'({$random(seed), $random(seed)});
        if (m[31]) m[7:0] = m[7:0] % 34;
        if (z) {a, b, m, hs} = {32'hFFFFFFFF, 32'h0, 32'h100, 1'b0};
        {is, pc, dp} = {is, pc, dp} & {3{o == 0 || o == 2}} & {2'h3, o == 0};
        s &= !(pc || dp);
        h = (o inside {11, 12}) ? h % 32 + 1 : h % 32;
        e = ref_f(o, pc ? a & iafl_pkg::PC_ALIGN : a, is ? {20'h0, i} : b,
            hs ? {2'h0, h} : m[7:0], ef, s, cv, cs);
        we = o < 16 && !dp;
        {req_valid, req_src_a, req_src_b, req_amt_reg} <= {1'b1, a, b, m};
        req_op <= iafl_pkg::iafl_op_t'(o);
        {req_imm_sel, req_short_imm, req_sh_imm_sel, req_sh_imm} <= {is, i, hs, h};
        {req_set_flags, req_sh_c_vld, req_sh_c, req_base_pc, req_dst_pc,
            req_dst_vld, req_dst_idx, req_src_idx} <= {s, cv, cs, pc, dp, dv, di, si};
        @(posedge aclk);
        req_valid <= 0;
        #1;
        chk(res_valid, 1);
        chk(res_data, e[31:0]);
        chk(flags_out, e[35:32]);
        chk(res_wr_en, we);
        chk(br_valid, dp);
        if (dp) chk(br_target, e[31:0] & iafl_pkg::BR_ALIGN);
        if (we && o < 15) chk(res_wr_idx, (dv || o >= 10) ? di : si);
        {ef, lr, rf_idx} = {e, res_wr_idx};
        @(posedge aclk);
        #1;
        if (we) chk(rf_q, e[31:0]);
    endtask
    // main sequence: reset, bus checks, every code twice, then random
    initial begin
        {req_valid, req_imm_sel, req_sh_imm_sel, req_set_flags, req_sh_c_vld,
            req_sh_c, req_base_pc, req_dst_pc, req_dst_vld, req_src_a, req_src_b,
            req_amt_reg, req_short_imm, req_sh_imm, req_dst_idx, req_src_idx,
            s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
            s_axi_araddr, s_axi_arvalid, s_axi_rready, ef} = '0;
        {req_op, s_axi_wstrb} = {iafl_pkg::OP_ADD, 4'hF};
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        ax(0, iafl_pkg::REG_FLAGS, 0);
        chk(q, 0);
        ax(1, iafl_pkg::REG_FLAGS, 32'h5);
        chk(rs, iafl_pkg::RESP_OKAY);
        // a write without the low byte lane must leave the flags alone
        s_axi_wstrb <= 4'hE;
        ax(1, iafl_pkg::REG_FLAGS, 32'hA);
        s_axi_wstrb <= 4'hF;
        ax(0, iafl_pkg::REG_FLAGS, 0);
        chk(q, 32'h5);
        ef = 4'h5;
        ax(0, 8'h10, 0);
        chk(rs, iafl_pkg::RESP_SLVERR);
        $display("test bus done");
        for (k = 0; k < 36; k++) op(5'(k % 18), k < 18);
        $display("test corner done");
        repeat (500) op(5'({$random(seed)} % 18), 0);
        ax(0, iafl_pkg::REG_RESULT, 0);
        chk(q, lr);
        // 36 corner plus 500 random operations were taken
        ax(0, iafl_pkg::REG_COUNT, 0);
        chk(q, 32'h218);
        $display("test random done");
        finish_test;
    end
endmodule
